// File: verilog/ckr_pkg.sv
package ckr_pkg;

    // clock and line timing
    localparam int unsigned CLK_HZ       = 50_000_000;  // system clock rate in hertz
    localparam int unsigned CHAR_RATE    = 10;          // characters per second, top rate
    localparam int unsigned FRAME_UNITS  = 11;          // start + 8 data + 2 stop units
    localparam int unsigned BAUD         = CHAR_RATE * FRAME_UNITS;  // unit rate, 110 per second
    localparam int unsigned OVS          = 16;          // oversampling ticks per unit
    localparam int unsigned OS_DIV       = CLK_HZ / (BAUD * OVS);    // clocks per tick, rounded down

    // oversample and bit counter marks, each at the width of its counter
    localparam logic [3:0]  OS_LAST      = 4'hf;        // last tick of a unit
    localparam logic [3:0]  OS_MID       = 4'h7;        // tick nearest the unit middle
    localparam logic [3:0]  OS_ZERO      = 4'h0;        // counter restart value
    localparam logic [2:0]  BIT_LAST     = 3'h7;        // index of the eighth data bit
    localparam logic [2:0]  BIT_ZERO     = 3'h0;        // first data bit index

    // instruction word fields (vector bit 0 is the least significant)
    localparam int unsigned SEL_LSB      = 3;           // device select field low bit
    localparam int unsigned SEL_MSB      = 8;           // device select field high bit
    localparam int unsigned OP_SKIP_BIT  = 0;           // enables the first pulse
    localparam int unsigned OP_CLR_BIT   = 1;           // enables the second pulse
    localparam int unsigned OP_XFER_BIT  = 2;           // enables the third pulse
    localparam logic [5:0]  SEL_RX       = 6'h03;       // receive select code
    localparam logic [5:0]  SEL_TX       = 6'h04;       // transmit select code

    // accumulator placement: character lands in the low eight bits
    localparam logic [3:0]  AC_HI_ZERO   = 4'h0;        // upper accumulator bits left zero

    // line levels
    localparam logic        LINE_MARK    = 1'b1;        // mark / hole / idle
    localparam logic        LINE_SPACE   = 1'b0;        // space / start element

    // receiver sequencing
    typedef enum logic [1:0] {
        CKR_IDLE  = 2'b00,
        CKR_START = 2'b01,
        CKR_DATA  = 2'b10,
        CKR_STOP  = 2'b11
    } ckr_state_t;

endpackage : ckr_pkg

// File: verilog/ckr_tick_if.sv
`timescale 1ns/1ps
// oversample tick carried from the divider to the receiver
interface ckr_tick_if;
    logic tick;  // one-cycle enable, sixteen per line unit

    modport src (output tick);
    modport snk (input  tick);
endinterface : ckr_tick_if

// File: verilog/ckr_tick_gen.sv
`timescale 1ns/1ps
module ckr_tick_gen #(
    parameter int unsigned DIV = ckr_pkg::OS_DIV
) (
    input  wire logic clk,
    input  wire logic reset_n,
    ckr_tick_if.src   tk
);

    localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;     // counter width
    localparam logic [CW-1:0] TOP = CW'(DIV - 1);                // wrap value

    // a divider below two would tick every clock and break the timing
    if (DIV < 2) begin : g_bad_div
        $error("ckr_tick_gen: DIV must be at least 2");
    end

    typedef struct packed {
        logic [CW-1:0] cnt;   // clocks since last tick
        logic          tick;  // registered enable
    } ckr_div_t;

    ckr_div_t q;
    ckr_div_t d;

    ////////////////////////////////////////////////////////////////////////////
    // free-running divider; the tick is one clock wide
    always_comb begin
        d      = q;
        d.tick = 1'b0;
        if (q.cnt == TOP) begin
            d.cnt  = '0;
            d.tick = 1'b1;
        end else begin
            d.cnt = q.cnt + CW'(1);
        end
        if (!reset_n) begin
            d = '0;
        end
    end

    always_ff @(posedge clk) begin
        q <= d;
    end

    assign tk.tick = q.tick;

endmodule : ckr_tick_gen

// File: verilog/ckr_rx_ctrl.sv
// Operation
// RULE1 - frame: start, eight data, two stop units
// RULE2 - space stores zero, mark stores one
// RULE3 - bit one is the character's least significant
// RULE4 - timing supports ten characters per second
// RULE5 - receive runs independent of transmit side
// RULE6 - select 03 receives, 04 transmits
// RULE7 - pulses: first skip, second clear, third transfer
// RULE8 - shift register holds last character until read
// RULE9 - character start drops reader relay, stops tape
// RULE10 - flag sets when eight bits assembled
// RULE11 - skip instruction skips when flag set
// RULE12 - read-and-clear clears, loads, re-enables tape feed
// RULE13 - clear instruction clears accumulator and flag
// RULE14 - after clear, loaded reader sends next frame
// RULE15 - otherwise keyboard character is assembled next
// RULE16 - interrupt enable gates flags onto request
// RULE17 - combined code clears, reads, flag sets again
// RULE18 - static read ORs character, clears nothing
// RULE19 - start edge detected, bits sampled mid-unit
`timescale 1ns/1ps
module ckr_rx_ctrl #(
    parameter int unsigned OS_DIV = ckr_pkg::OS_DIV  // clocks per oversample tick
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        rx_line,
    input  wire logic [11:0] instr_word,
    input  wire logic        skip_pulse,
    input  wire logic        clear_pulse,
    input  wire logic        transfer_pulse,
    input  wire logic        interrupt_enable_op,
    input  wire logic        int_enable_value,
    input  wire logic        tx_flag,
    output logic             reader_relay_q,
    output logic             rx_flag_q,
    output logic             skip_req_q,
    output logic             ac_clear_q,
    output logic [11:0]      ac_data_q,
    output logic             ac_strobe_q,
    output logic             tx_select_q,
    output logic             int_request_q
);

    ////////////////////////////////////////////////////////////////////////////
    // elaboration checks

    // the oversample counter is four bits wide and its marks assume sixteen
    if (ckr_pkg::OVS != 16) begin : g_bad_ovs
        $error("ckr_rx_ctrl: oversampling must be sixteen");
    end

    // a very small divider still works, but one below two ticks every clock
    if (OS_DIV < 2) begin : g_bad_div
        $error("ckr_rx_ctrl: OS_DIV must be at least 2");
    end

    ////////////////////////////////////////////////////////////////////////////
    // state of the whole control, one packed record

    typedef struct packed {
        ckr_pkg::ckr_state_t st;         // receiver sequencing state
        logic [3:0]          os_cnt;     // oversample ticks within a unit
        logic [2:0]          bit_cnt;    // data bit index, 0 = first received
        logic [7:0]          shreg;      // receive_char_register
        logic                line_prev;  // line level one clock ago
        logic                rx_flag;    // character ready
        logic                int_en;     // interrupt enable
        logic                relay;      // reader relay, 1 = energized
        logic                skip;       // skip request pulse
        logic                ac_clr;     // accumulator clear pulse
        logic [11:0]         ac_data;    // value offered to the accumulator
        logic                ac_stb;     // data transfer pulse
        logic                tx_sel;     // transmit select pulse
        logic                irq;        // interrupt request level
    } ckr_rx_regs_t;

    ckr_rx_regs_t q;                     // registered state
    ckr_rx_regs_t d;                     // next state

    logic [5:0]   dev_sel;               // select field of the instruction
    logic         sel_rx;                // instruction addresses the receiver
    logic         sel_tx;                // instruction addresses the transmitter
    logic         any_pulse;             // any of the three io pulses
    logic         set_flag;              // a frame finished this clock

    ////////////////////////////////////////////////////////////////////////////
    // oversample tick source

    ckr_tick_if tick_bus ();             // carries the divider's enable

    ckr_tick_gen #(
        .DIV (OS_DIV)
    ) u_tick (
        .clk     (clk),
        .reset_n (reset_n),
        .tk      (tick_bus)
    );

    ////////////////////////////////////////////////////////////////////////////
    // instruction decode

    // select code sits in the middle six bits of the io instruction
    always_comb begin
        dev_sel   = instr_word[ckr_pkg::SEL_MSB:ckr_pkg::SEL_LSB];
        sel_rx    = (dev_sel == ckr_pkg::SEL_RX);  // RULE6
        sel_tx    = (dev_sel == ckr_pkg::SEL_TX);  // RULE6
        any_pulse = skip_pulse | clear_pulse | transfer_pulse;
    end

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic

    always_comb begin
        d          = q;
        set_flag   = 1'b0;
        // single-cycle outputs fall back every clock
        d.skip     = 1'b0;
        d.ac_clr   = 1'b0;
        d.ac_stb   = 1'b0;
        d.tx_sel   = 1'b0;
        // inputs are synchronous, so one register gives the edge reference
        d.line_prev = rx_line;

        // receiver: runs on its own, whatever the transmit side does
        unique case (q.st)  // RULE5
            ckr_pkg::CKR_IDLE: begin
                // a new frame only starts once software has freed the register;
                // the keyboard and the reader share the one line, so whichever
                // source is active supplies the next character
                if (!q.rx_flag && q.line_prev == ckr_pkg::LINE_MARK
                        && rx_line == ckr_pkg::LINE_SPACE) begin  // RULE19 RULE14 RULE15
                    d.st     = ckr_pkg::CKR_START;
                    d.os_cnt = ckr_pkg::OS_ZERO;
                    d.relay  = 1'b0;                   // RULE9
                end
            end
            ckr_pkg::CKR_START: begin
                if (tick_bus.tick) begin
                    if (q.os_cnt == ckr_pkg::OS_MID) begin
                        // re-check mid start: a short glitch is not a frame
                        if (rx_line == ckr_pkg::LINE_SPACE) begin  // RULE19
                            d.st      = ckr_pkg::CKR_DATA;
                            d.bit_cnt = ckr_pkg::BIT_ZERO;
                        end else begin
                            d.st = ckr_pkg::CKR_IDLE;
                        end
                        d.os_cnt = ckr_pkg::OS_ZERO;
                    end else begin
                        d.os_cnt = q.os_cnt + 4'h1;
                    end
                end
            end
            ckr_pkg::CKR_DATA: begin
                if (tick_bus.tick) begin
                    if (q.os_cnt == ckr_pkg::OS_LAST) begin
                        // one unit on from the start middle = this bit's middle;
                        // first bit in ends up in bit 0, the least significant
                        d.shreg  = {rx_line, q.shreg[7:1]};  // RULE2 RULE3 RULE8
                        d.os_cnt = ckr_pkg::OS_ZERO;
                        if (q.bit_cnt == ckr_pkg::BIT_LAST) begin
                            d.st = ckr_pkg::CKR_STOP;  // RULE1
                        end else begin
                            d.bit_cnt = q.bit_cnt + 3'h1;
                        end
                    end else begin
                        d.os_cnt = q.os_cnt + 4'h1;
                    end
                end
            end
            ckr_pkg::CKR_STOP: begin
                if (tick_bus.tick) begin
                    // flag at the middle of the first stop unit; the second stop
                    // unit passes in idle, and the start edge needs the mark
                    // anyway, so a short stop costs nothing but a late frame
                    if (q.os_cnt == ckr_pkg::OS_LAST) begin
                        set_flag = 1'b1;               // RULE10 RULE17
                        d.st     = ckr_pkg::CKR_IDLE;
                        d.os_cnt = ckr_pkg::OS_ZERO;
                    end else begin
                        d.os_cnt = q.os_cnt + 4'h1;
                    end
                end
            end
        endcase

        // first pulse: skip when the flag is up
        if (skip_pulse && sel_rx && instr_word[ckr_pkg::OP_SKIP_BIT]
                && q.rx_flag) begin                    // RULE7 RULE11
            d.skip = 1'b1;
        end

        // second pulse: clear flag and accumulator, let the tape move again
        if (clear_pulse && sel_rx && instr_word[ckr_pkg::OP_CLR_BIT]) begin  // RULE7
            d.rx_flag = 1'b0;                          // RULE13 RULE12
            d.ac_clr  = 1'b1;                          // RULE13 RULE12
            d.relay   = 1'b1;                          // RULE12 RULE14
        end

        // third pulse: offer the character; the processor ORs it in, so a
        // read without the clear bit leaves accumulator and flag alone
        if (transfer_pulse && sel_rx && instr_word[ckr_pkg::OP_XFER_BIT]) begin  // RULE7
            d.ac_data = {ckr_pkg::AC_HI_ZERO, q.shreg};  // RULE18 RULE12 RULE17
            d.ac_stb  = 1'b1;
        end

        // hardware set beats a clear in the same clock
        if (set_flag) begin
            d.rx_flag = 1'b1;
        end

        // transmit-side select is only announced; that side lives elsewhere
        d.tx_sel = any_pulse && sel_tx;                // RULE6

        // interrupt enable and the request it gates
        if (interrupt_enable_op) begin
            d.int_en = int_enable_value;               // RULE16
        end
        d.irq = d.int_en && (d.rx_flag || tx_flag);    // RULE16

        // synchronous reset: idle line, relay energized, everything else clear
        if (!reset_n) begin
            d           = '0;
            d.st        = ckr_pkg::CKR_IDLE;
            d.line_prev = ckr_pkg::LINE_MARK;
            d.relay     = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge clk) begin
        q <= d;
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, each straight from the state record

    assign reader_relay_q = q.relay;
    assign rx_flag_q      = q.rx_flag;
    assign skip_req_q     = q.skip;
    assign ac_clear_q     = q.ac_clr;
    assign ac_data_q      = q.ac_data;
    assign ac_strobe_q    = q.ac_stb;
    assign tx_select_q    = q.tx_sel;
    assign int_request_q  = q.irq;

endmodule : ckr_rx_ctrl

// File: bench/ckr_kbd_model.sv
`timescale 1ns/1ps
// far end: keyboard or tape reader on a current loop, idles at mark
module ckr_kbd_model #(
    parameter int unsigned UNIT = 64  // clocks per line unit (16 ticks of the divider)
) (
    input  wire logic clk,
    output logic      rx_line
);
    // loop current flows while idle, so the line rests at mark
    initial rx_line = ckr_pkg::LINE_MARK;

    ////////////////////////////////////////////////////////////////////////////////
    // one frame: start space, eight bits low bit first, two stop marks
    task automatic send_char(input logic [7:0] ch);
        logic [10:0] fr;  // frame, element 0 goes out first
        fr = {2'b11, ch, ckr_pkg::LINE_SPACE};
        for (int i = 0; i < 11; i++) begin
            @(posedge clk);
            rx_line <= fr[i];
            repeat (UNIT - 1) @(posedge clk);
        end
    endtask : send_char
endmodule : ckr_kbd_model

// File: bench/ckr_rx_checker.sv
`timescale 1ns/1ps
module ckr_rx_checker #(
    parameter int unsigned OS_DIV = ckr_pkg::OS_DIV  // clocks per oversample tick
) (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        rx_line,
    input wire logic [11:0] instr_word,
    input wire logic        skip_pulse,
    input wire logic        clear_pulse,
    input wire logic        transfer_pulse,
    input wire logic        interrupt_enable_op,
    input wire logic        int_enable_value,
    input wire logic        tx_flag,
    input wire logic        reader_relay_q,
    input wire logic        rx_flag_q,
    input wire logic        skip_req_q,
    input wire logic        ac_clear_q,
    input wire logic [11:0] ac_data_q,
    input wire logic        ac_strobe_q,
    input wire logic        tx_select_q,
    input wire logic        int_request_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    localparam int unsigned FLAG_LO = 150 * OS_DIV;  // earliest flag, clocks after relay drop
    localparam int unsigned FLAG_HI = 154 * OS_DIV;  // latest, allows tick phase slack
    logic        rx_sel;   // instruction addresses the receive side
    logic        clr_cmd;  // selected clear pulse
    logic [31:0] low_q;    // cycles the relay has been released
    assign rx_sel  = instr_word[8:3] == ckr_pkg::SEL_RX;
    assign clr_cmd = rx_sel && clear_pulse && instr_word[ckr_pkg::OP_CLR_BIT];
    // counts the frame from its start, since a delay range cannot reach real rates
    always_ff @(posedge clk) begin
        low_q <= (!reset_n || reader_relay_q) ? 32'h0 : low_q + 32'h1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    chk_skip_set: assert property (rx_sel && skip_pulse && instr_word[0] && rx_flag_q |=> skip_req_q)
        else $error("skip missing with flag set");
    chk_skip_cause: assert property (skip_req_q |-> $past(rx_sel && skip_pulse && rx_flag_q))
        else $error("skip without selected first pulse and flag");
    chk_clear_ack: assert property (clr_cmd |=> ac_clear_q)
        else $error("accumulator clear missing");
    chk_flag_clear: assert property (clr_cmd && rx_flag_q |=> !rx_flag_q && reader_relay_q)
        else $error("flag or relay wrong after clear");
    chk_xfer_data: assert property (rx_sel && transfer_pulse && instr_word[2] |=>
        ac_strobe_q && ac_data_q[11:8] == ckr_pkg::AC_HI_ZERO)
        else $error("transfer strobe or upper bits wrong");
    chk_strobe_cause: assert property (ac_strobe_q |-> $past(rx_sel && transfer_pulse))
        else $error("strobe without selected third pulse");
    chk_relay_drop: assert property ($fell(rx_line) && reader_relay_q && !rx_flag_q && !clear_pulse
        |=> !reader_relay_q)
        else $error("relay kept energized at start element");
    chk_flag_hold: assert property (rx_flag_q && !clr_cmd |=> rx_flag_q)
        else $error("flag dropped without clear");
    chk_flag_time: assert property ($rose(rx_flag_q) |-> low_q >= FLAG_LO && low_q <= FLAG_HI)
        else $error("flag set at wrong frame time");
    chk_tx_select: assert property (instr_word[8:3] == ckr_pkg::SEL_TX && skip_pulse |=> tx_select_q)
        else $error("transmit select missing");
    chk_int_cause: assert property (int_request_q |-> rx_flag_q || $past(tx_flag))
        else $error("interrupt request without flag");
    cov_skip:  cover property (skip_req_q);
    cov_flag:  cover property ($rose(rx_flag_q));
    cov_strobe: cover property (ac_strobe_q);
    cov_int:   cover property (int_request_q);
endmodule : ckr_rx_checker

bind ckr_rx_ctrl ckr_rx_checker #(.OS_DIV(OS_DIV)) chk_i (.clk, .reset_n, .rx_line, .instr_word,
    .skip_pulse, .clear_pulse, .transfer_pulse, .interrupt_enable_op, .int_enable_value, .tx_flag,
    .reader_relay_q, .rx_flag_q, .skip_req_q, .ac_clear_q, .ac_data_q, .ac_strobe_q, .tx_select_q,
    .int_request_q);

// File: bench/console_keyboard_receiver_control_tb.sv
`timescale 1ns/1ps
module console_keyboard_receiver_control_tb;
    logic        clk, reset_n, skip_pulse, clear_pulse, transfer_pulse;  // clock and io pulses
    logic        interrupt_enable_op, int_enable_value, tx_flag;         // interrupt controls
    logic        reader_relay_q, rx_flag_q, skip_req_q, ac_clear_q;      // control outputs
    logic        ac_strobe_q, tx_select_q, int_request_q;                // more outputs
    logic        rx_line;       // serial line from the far end
    logic [11:0] instr_word;    // io instruction
    logic [11:0] ac_data_q;     // character towards accumulator
    logic [11:0] exp_q[$];      // expected transfers, oldest first
    logic [7:0]  ch;            // character in flight
    int          err_count, cmp_count, seed;
    localparam logic [5:0] RX = ckr_pkg::SEL_RX;  // receive select, at the field width

    // divider of 4 gives 64 clocks per unit, keeping frames short
    ckr_rx_ctrl #(.OS_DIV(4)) ckr_rx_ctrl_i (.clk, .reset_n, .rx_line, .instr_word, .skip_pulse,
        .clear_pulse, .transfer_pulse, .interrupt_enable_op, .int_enable_value, .tx_flag,
        .reader_relay_q, .rx_flag_q, .skip_req_q, .ac_clear_q, .ac_data_q, .ac_strobe_q,
        .tx_select_q, .int_request_q);
    ckr_kbd_model #(.UNIT(64)) ckr_kbd_model_i (.clk, .rx_line);

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("compares=%0d mismatches=%0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish

    // one instruction: enabled pulses go out in order, answers checked a cycle later
    task automatic io(input logic [5:0] sel, input logic [2:0] ops, input logic fl);
        for (int k = 0; k < 3; k++) if (ops[k]) begin
            @(posedge clk);
            instr_word     <= {3'h6, sel, ops};
            skip_pulse     <= (k == 0);
            clear_pulse    <= (k == 1);
            transfer_pulse <= (k == 2);
            if (k == 2 && sel == RX) exp_q.push_back({4'h0, ch});
            @(posedge clk);
            {skip_pulse, clear_pulse, transfer_pulse} <= 3'h0;
            #1;
            check(12'(skip_req_q), 12'(k == 0 && sel == RX && fl));
            check(12'(ac_clear_q), 12'(k == 1 && sel == RX));
            check(12'(tx_select_q), 12'(sel == ckr_pkg::SEL_TX));
        end
    endtask : io

    // every strobe pairs with the oldest noted transfer; looked at mid-cycle, when settled
    always @(negedge clk) begin
        if (ac_strobe_q === 1'b1) begin
            if (exp_q.size() == 0) check(ac_data_q, 12'hfff);
            else check(ac_data_q, exp_q.pop_front());
        end
    end

    // watchdog: six frames of 704 clocks plus margin
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        tally_and_finish();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {reset_n, skip_pulse, clear_pulse, transfer_pulse} = 4'h0;
        {interrupt_enable_op, int_enable_value, tx_flag} = 3'h0;
        instr_word = 12'h000;
        seed = 32'hf1224ecd;
        ch = 8'h00;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        #1;
        check({5'h0, reader_relay_q, rx_flag_q, skip_req_q, ac_clear_q, ac_strobe_q,
            tx_select_q, int_request_q}, 12'h040);
        // no flag, foreign and transmit selects: nothing but tx select answers
        io(RX, 3'h1, 1'b0);
        io(6'h05, 3'h7, 1'b0);
        io(ckr_pkg::SEL_TX, 3'h7, 1'b0);
        $display("test selects done");
        for (int n = 0; n < 4; n++) begin
            ch = (n == 1) ? 8'hff : (n == 2) ? 8'h00 : 8'($random(seed));
            ckr_kbd_model_i.send_char(ch);
            check(12'(rx_flag_q), 12'h001);
            check(12'(reader_relay_q), 12'h000);
            io(RX, 3'h1, 1'b1);
            if (n == 0) begin
                io(RX, 3'h4, 1'b1);
                check(12'(rx_flag_q), 12'h001);
                ckr_kbd_model_i.send_char(~ch);  // ignored: flag still set
            end
            if (n[0]) io(RX, 3'h2, 1'b1);
            else io(RX, 3'h6, 1'b1);
            check({10'h0, rx_flag_q, reader_relay_q}, 12'h001);
        end
        $display("test frames done");
        @(posedge clk);
        interrupt_enable_op <= 1'b1;
        int_enable_value    <= 1'b1;
        tx_flag             <= 1'b1;
        @(posedge clk);
        interrupt_enable_op <= 1'b0;
        repeat (3) @(posedge clk);
        check(12'(int_request_q), 12'h001);
        tx_flag <= 1'b0;
        repeat (3) @(posedge clk);
        check(12'(int_request_q), 12'h000);
        ch = 8'($random(seed));
        ckr_kbd_model_i.send_char(ch);
        check(12'(int_request_q), 12'h001);
        interrupt_enable_op <= 1'b1;
        int_enable_value    <= 1'b0;
        @(posedge clk);
        interrupt_enable_op <= 1'b0;
        repeat (3) @(posedge clk);
        check(12'(int_request_q), 12'h000);
        io(RX, 3'h6, 1'b1);
        repeat (3) @(posedge clk);
        check(12'(exp_q.size()), 12'h000);
        $display("test interrupt done");
        tally_and_finish();
    end
endmodule : console_keyboard_receiver_control_tb
